// ===== rtl/osd_display_memory.sv
`timescale 1ns/1ps
`default_nettype none
module osd_display_memory #(
  parameter int ADDR_W = 9
) (
  input wire logic i_ref_clk,
  input wire logic i_ce,
  input wire logic i_we_code,
  input wire logic i_we_attr,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire osd_pkg::dmem_entry_type i_wdata,
  output osd_pkg::dmem_entry_type o_rdata
);
  import osd_pkg::*;

  // Contents are data, not control state, so they carry no reset.
  dmem_entry_type mem_q [2**ADDR_W];

  always_ff @(posedge i_ref_clk)
  begin
    if (i_ce && i_we_code)
      mem_q[i_addr].char_code <= i_wdata.char_code;
    if (i_ce && i_we_attr)
      mem_q[i_addr].attr <= i_wdata.attr;
  end

  assign o_rdata = mem_q[i_addr];
endmodule
`default_nettype wire

// ===== rtl/osd_pkg.sv
// Summary of operation
// - Raster blanking paints whole screen in colour.
// - Colour code: intensity plus RGB, sixteen colours.
// - Two area planes; plane one wins overlap.
// - Plane one colour low nibble, two high.
// - Line counter clears on vertical, counts rows.
// - Blank or off rows still advance counter.
// - Line field zero fires on clear, else row.
// - Register writes take effect immediately.
// - Bank bit picks single or combined access.
// - Normal mode increments address after each code-low or single-mode attribute access.
// - Single writes store data and increment address.
// - Combined attribute write holds; code write commits.
// - Modify mode reads keep address, writes increment.
package osd_pkg;

  localparam logic [7:0] OFS_RASTER_AREA_CONTROL = 8'h00;
  localparam logic [7:0] OFS_AREA_PLANE_COLORS = 8'h04;
  localparam logic [7:0] OFS_OSD_INTERRUPT_CONTROL = 8'h08;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h0C;
  localparam logic [7:0] OFS_ADDR_LOW = 8'h10;
  localparam logic [7:0] OFS_CODE_HIGH = 8'h14;
  localparam logic [7:0] OFS_CODE_LOW = 8'h18;
  localparam logic [7:0] OFS_ATTRIBUTE = 8'h1C;
  localparam logic [7:0] OFS_OSD_MISC_CONTROL = 8'h20;
  localparam logic [7:0] OFS_PIN_OUTPUT_SELECT = 8'h24;
  localparam logic [7:0] OFS_LINE_COUNTER = 8'h28;
  localparam logic [7:0] OFS_WINDOW_TOP = 8'h2C;
  localparam logic [7:0] OFS_WINDOW_BOTTOM = 8'h30;
  localparam logic [7:0] OFS_ROW_HEIGHT = 8'h34;
  localparam logic [7:0] OFS_PLANE1_RECT = 8'h38;
  localparam logic [7:0] OFS_PLANE2_RECT = 8'h3C;

  localparam int BIT_RASTER_BLANK_ENABLE = 6;
  localparam int BIT_PLANE2_ON = 5;
  localparam int BIT_PLANE1_ON = 4;
  localparam int BIT_IRQ_SOURCE_SELECT = 4;
  localparam int BIT_WINDOW_ENABLE = 0;
  localparam int BIT_COMBINED_BANK_SELECT = 1;
  localparam int BIT_READ_DIRECTION_SELECT = 2;
  localparam int BIT_MODIFY_WRITE_MODE = 3;
  localparam int BIT_BLANK_OUTPUT_SELECT = 2;

  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [8:0] RST_WINDOW_TOP = 9'h001;
  localparam logic [8:0] RST_WINDOW_BOTTOM = 9'h1FE;
  localparam logic [7:0] RST_ROW_HEIGHT = 8'h12;
  localparam logic [31:0] RST_RECT = 32'h0000_0000;

  typedef struct packed {
    logic intensity;
    logic red;
    logic green;
    logic blue;
  } color_type;

  typedef struct packed {
    logic [8:0] char_code;
    logic [6:0] attr;
  } dmem_entry_type;

  typedef enum logic [1:0] {
    ST_SETUP = 2'b01,
    ST_READY = 2'b10
  } apb_state_type;

endpackage

// ===== rtl/osd_pulse_sync.sv
`timescale 1ns/1ps
`default_nettype none
module osd_pulse_sync (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_pulse,
  output logic o_rise,
  output logic o_fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else if (i_ce)
    begin
      meta_q <= i_pulse;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_rise = i_ce & sync_q & ~prev_q;
  assign o_fall = i_ce & ~sync_q & prev_q;
endmodule
`default_nettype wire

// ===== rtl/osd_screen_planes.sv
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module osd_screen_planes #(
  parameter int ADDR_W = 9
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic i_horizontal_timing_pulse,
  input wire logic i_vertical_timing_pulse_n,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  output osd_pkg::color_type o_osd_color,
  output logic o_osd_blank,
  output logic o_blank_output_select,
  output logic o_irq
);
  import osd_pkg::*;

  apb_state_type state_q;
  logic [31:0] prdata_q, plane1_rect_q, plane2_rect_q;
  logic [7:0] raster_area_control_q, area_plane_colors_q, osd_interrupt_control_q;
  logic [7:0] osd_misc_control_q, pin_output_select_q, row_height_q, row_scan_q, hpos_q;
  logic [8:0] window_top_q, window_bottom_q, scan_q;
  logic [ADDR_W-1:0] display_mem_addr_q;
  logic [6:0] attr_hold_q;
  logic [3:0] display_line_counter_q;
  color_type color_q;
  logic pslverr_q, code_msb_q, blank_q, irq_q;
  wire h_rise, h_fall, v_rise, v_fall;
  dmem_entry_type mem_rdata;

  // The vertical pulse is active low, so its falling edge starts a field.
  osd_pulse_sync u_hsync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_pulse(i_horizontal_timing_pulse),
    .o_rise(h_rise),
    .o_fall(h_fall)
  );
  osd_pulse_sync u_vsync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_pulse(i_vertical_timing_pulse_n),
    .o_rise(v_rise),
    .o_fall(v_fall)
  );

  // Bus decode. A write lands at the edge where ready is sampled high.
  wire setup_read = i_psel & i_penable & (state_q == ST_SETUP);
  wire done = i_psel & i_penable & (state_q == ST_READY);
  wire wr_done = done & i_pwrite;
  wire rd_done = done & ~i_pwrite;
  wire wr_raster = wr_done & (i_paddr == OFS_RASTER_AREA_CONTROL);
  wire wr_colors = wr_done & (i_paddr == OFS_AREA_PLANE_COLORS);
  wire wr_irqc = wr_done & (i_paddr == OFS_OSD_INTERRUPT_CONTROL);
  wire wr_misc = wr_done & (i_paddr == OFS_OSD_MISC_CONTROL);
  wire wr_pins = wr_done & (i_paddr == OFS_PIN_OUTPUT_SELECT);
  wire wr_top = wr_done & (i_paddr == OFS_WINDOW_TOP);
  wire wr_bottom = wr_done & (i_paddr == OFS_WINDOW_BOTTOM);
  wire wr_rowh = wr_done & (i_paddr == OFS_ROW_HEIGHT);
  wire wr_rect1 = wr_done & (i_paddr == OFS_PLANE1_RECT);
  wire wr_rect2 = wr_done & (i_paddr == OFS_PLANE2_RECT);
  wire wr_addr_hi = wr_done & (i_paddr == OFS_ADDR_HIGH);
  wire wr_addr_lo = wr_done & (i_paddr == OFS_ADDR_LOW);
  wire wr_code_hi = wr_done & (i_paddr == OFS_CODE_HIGH);
  wire wr_code_lo = wr_done & (i_paddr == OFS_CODE_LOW);
  wire wr_attr = wr_done & (i_paddr == OFS_ATTRIBUTE);
  wire rd_code_lo = rd_done & (i_paddr == OFS_CODE_LOW);
  wire rd_attr = rd_done & (i_paddr == OFS_ATTRIBUTE);
  wire known = (i_paddr[1:0] == 2'b00) && (i_paddr <= OFS_PLANE2_RECT);

  // Display memory port sequencing.
  wire combined = osd_misc_control_q[BIT_COMBINED_BANK_SELECT];
  wire modify = osd_misc_control_q[BIT_MODIFY_WRITE_MODE];
  wire mem_we_code = wr_code_lo;
  wire mem_we_attr = (wr_attr & ~combined) | (wr_code_lo & combined);
  wire [6:0] mem_attr = combined ? attr_hold_q : i_pwdata[6:0];
  wire inc_write = wr_code_lo | (wr_attr & ~combined);
  wire inc_read = ~modify & (rd_code_lo | (rd_attr & ~combined));
  wire addr_inc = inc_write | inc_read;
  dmem_entry_type mem_wdata;
  assign mem_wdata = '{char_code: {code_msb_q, i_pwdata[7:0]}, attr: mem_attr};

  osd_display_memory #(
    .ADDR_W(ADDR_W)
  ) u_mem (
    .i_ref_clk(i_ref_clk),
    .i_ce(i_ce),
    .i_we_code(mem_we_code),
    .i_we_attr(mem_we_attr),
    .i_addr(display_mem_addr_q),
    .i_wdata(mem_wdata),
    .o_rdata(mem_rdata)
  );

  logic [31:0] rdata_mux;
  always_comb
  begin
    rdata_mux = 32'h0000_0000;
    unique case (i_paddr)
      OFS_RASTER_AREA_CONTROL: rdata_mux[7:0] = raster_area_control_q;
      OFS_AREA_PLANE_COLORS: rdata_mux[7:0] = area_plane_colors_q;
      OFS_OSD_INTERRUPT_CONTROL: rdata_mux[7:0] = osd_interrupt_control_q;
      OFS_ADDR_HIGH: rdata_mux[0] = display_mem_addr_q[ADDR_W-1];
      OFS_ADDR_LOW: rdata_mux[7:0] = display_mem_addr_q[7:0];
      OFS_CODE_HIGH: rdata_mux[0] = mem_rdata.char_code[8];
      OFS_CODE_LOW: rdata_mux[7:0] = mem_rdata.char_code[7:0];
      OFS_ATTRIBUTE: rdata_mux[6:0] = mem_rdata.attr;
      OFS_OSD_MISC_CONTROL: rdata_mux[7:0] = osd_misc_control_q;
      OFS_PIN_OUTPUT_SELECT: rdata_mux[7:0] = pin_output_select_q;
      OFS_LINE_COUNTER: rdata_mux[3:0] = display_line_counter_q;
      OFS_WINDOW_TOP: rdata_mux[8:0] = window_top_q;
      OFS_WINDOW_BOTTOM: rdata_mux[8:0] = window_bottom_q;
      OFS_ROW_HEIGHT: rdata_mux[7:0] = row_height_q;
      OFS_PLANE1_RECT: rdata_mux = plane1_rect_q;
      OFS_PLANE2_RECT: rdata_mux = plane2_rect_q;
      default: rdata_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q <= ST_SETUP;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (i_ce)
    begin
      if (setup_read)
      begin
        state_q <= ST_READY;
        prdata_q <= rdata_mux;
        pslverr_q <= ~known;
      end
      else
      begin
        state_q <= ST_SETUP;
        pslverr_q <= 1'b0;
      end
    end
  end

  // Control registers pass to the display logic the moment they are written.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      raster_area_control_q <= RST_CONTROL;
      area_plane_colors_q <= RST_CONTROL;
      osd_interrupt_control_q <= RST_CONTROL;
      osd_misc_control_q <= RST_CONTROL;
      pin_output_select_q <= RST_CONTROL;
      window_top_q <= RST_WINDOW_TOP;
      window_bottom_q <= RST_WINDOW_BOTTOM;
      row_height_q <= RST_ROW_HEIGHT;
      plane1_rect_q <= RST_RECT;
      plane2_rect_q <= RST_RECT;
    end
    else if (i_ce)
    begin
      if (wr_raster) raster_area_control_q <= i_pwdata[7:0];
      if (wr_colors) area_plane_colors_q <= i_pwdata[7:0];
      if (wr_irqc) osd_interrupt_control_q <= i_pwdata[7:0];
      if (wr_misc) osd_misc_control_q <= i_pwdata[7:0];
      if (wr_pins) pin_output_select_q <= i_pwdata[7:0];
      if (wr_top) window_top_q <= i_pwdata[8:0];
      if (wr_bottom) window_bottom_q <= i_pwdata[8:0];
      if (wr_rowh) row_height_q <= i_pwdata[7:0];
      if (wr_rect1) plane1_rect_q <= i_pwdata;
      if (wr_rect2) plane2_rect_q <= i_pwdata;
    end
  end

  // The top address bit goes into the address at once; the low byte write sets only bits 7 to 0.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      display_mem_addr_q <= '0;
      code_msb_q <= 1'b0;
      attr_hold_q <= 7'h00;
    end
    else if (i_ce)
    begin
      if (wr_addr_hi) display_mem_addr_q[ADDR_W-1] <= i_pwdata[0];
      else if (wr_addr_lo) display_mem_addr_q[7:0] <= i_pwdata[7:0];
      else if (addr_inc) display_mem_addr_q <= display_mem_addr_q + 1'b1;
      if (wr_code_hi) code_msb_q <= i_pwdata[0];
      if (wr_attr && combined) attr_hold_q <= i_pwdata[6:0];
    end
  end

  // Scan and display-row tracking; empty or hidden rows count the same.
  wire row_end = h_fall && (row_scan_q == row_height_q - 8'd1);
  wire [3:0] line_next = display_line_counter_q + 4'd1;
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      display_line_counter_q <= 4'h0;
      row_scan_q <= 8'h00;
      scan_q <= 9'h000;
      hpos_q <= 8'h00;
    end
    else if (i_ce)
    begin
      if (v_fall)
      begin
        display_line_counter_q <= 4'h0;
        row_scan_q <= 8'h00;
        scan_q <= 9'h000;
      end
      else if (h_fall)
      begin
        scan_q <= scan_q + 9'd1;
        row_scan_q <= row_end ? 8'h00 : row_scan_q + 8'd1;
        if (row_end) display_line_counter_q <= line_next;
      end
      if (h_rise) hpos_q <= 8'h00;
      else if (hpos_q != 8'hFF) hpos_q <= hpos_q + 8'd1;
    end
  end

  // Rect layout: h start, h stop, v start, v stop, one byte each, low first.
  function automatic logic plane_hit(input logic [31:0] rect, input logic [7:0] h, v);
    plane_hit = (h >= rect[7:0]) && (h < rect[15:8]) && (v >= rect[23:16]) && (v < rect[31:24]);
  endfunction

  wire win_on = osd_misc_control_q[BIT_WINDOW_ENABLE];
  wire in_window = ~win_on | ((scan_q >= window_top_q) && (scan_q < window_bottom_q));
  wire hit1 = in_window & raster_area_control_q[BIT_PLANE1_ON] &
              plane_hit(plane1_rect_q, hpos_q, scan_q[7:0]);
  wire hit2 = in_window & raster_area_control_q[BIT_PLANE2_ON] &
              plane_hit(plane2_rect_q, hpos_q, scan_q[7:0]);
  wire raster_on = raster_area_control_q[BIT_RASTER_BLANK_ENABLE];
  color_type plane1_color, plane2_color, raster_color, color_d;
  assign plane1_color = color_type'(area_plane_colors_q[3:0]);
  assign plane2_color = color_type'(area_plane_colors_q[7:4]);
  assign raster_color = color_type'(raster_area_control_q[3:0]);
  assign color_d = hit1 ? plane1_color : hit2 ? plane2_color :
                   raster_on ? raster_color : color_type'(4'h0);

  // Zero in the line field means the clear itself raises the request.
  wire [3:0] irq_line = osd_interrupt_control_q[3:0];
  wire src_vertical = osd_interrupt_control_q[BIT_IRQ_SOURCE_SELECT];
  wire irq_d = (src_vertical | (irq_line == 4'h0)) ? v_fall :
               (~v_fall & row_end & (line_next == irq_line));

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      color_q <= color_type'(4'h0);
      blank_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else if (i_ce)
    begin
      color_q <= color_d;
      blank_q <= hit1 | hit2 | raster_on;
      irq_q <= irq_d;
    end
  end

  // The blank pin mode is left to software before raster blanking is used.
  assign o_blank_output_select = pin_output_select_q[BIT_BLANK_OUTPUT_SELECT];
  assign o_pready = state_q[1];
  assign o_prdata = prdata_q;
  assign o_pslverr = pslverr_q;
  assign o_osd_color = color_q;
  assign o_osd_blank = blank_q;
  assign o_irq = irq_q;

  property p_irq_single;
    @(posedge i_ref_clk) disable iff (!i_rst_n) o_irq && i_ce |=> !o_irq;
  endproperty
  a_irq_single: assert property (p_irq_single) else $error("irq wider than one cycle");
  property p_vert_clear;
    @(posedge i_ref_clk) disable iff (!i_rst_n) v_fall |=> display_line_counter_q == 4'h0;
  endproperty
  a_vert_clear: assert property (p_vert_clear) else $error("line counter not cleared");
  property p_row_advance;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      row_end && !v_fall |=> display_line_counter_q == $past(display_line_counter_q) + 4'd1;
  endproperty
  a_row_advance: assert property (p_row_advance) else $error("line counter missed row");
  property p_irq_vertical;
    @(posedge i_ref_clk) disable iff (!i_rst_n) v_fall && src_vertical |=> o_irq;
  endproperty
  a_irq_vertical: assert property (p_irq_vertical) else $error("no vertical irq");
  property p_irq_line;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      !src_vertical && irq_line != 4'h0 && !v_fall && row_end && line_next == irq_line
      |=> o_irq && display_line_counter_q == $past(irq_line);
  endproperty
  a_irq_line: assert property (p_irq_line) else $error("line irq wrong");
  property p_plane_priority;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_ce && hit1 |=> o_osd_color == $past(plane1_color) && o_osd_blank;
  endproperty
  a_plane_priority: assert property (p_plane_priority) else $error("plane 1 lost");
  property p_raster_fill;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_ce && raster_on && !hit1 && !hit2 |=> o_osd_blank && o_osd_color == $past(raster_color);
  endproperty
  a_raster_fill: assert property (p_raster_fill) else $error("raster not painted");
  property p_code_write_inc;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_ce && wr_code_lo |=> display_mem_addr_q == $past(display_mem_addr_q) + 1'b1;
  endproperty
  a_code_write_inc: assert property (p_code_write_inc) else $error("no increment");
  property p_combined_hold;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_ce && wr_attr && combined |=> $stable(display_mem_addr_q) &&
      attr_hold_q == $past(i_pwdata[6:0]);
  endproperty
  a_combined_hold: assert property (p_combined_hold) else $error("combined attr moved");
  property p_modify_read;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_ce && modify && rd_done && !wr_done |=> $stable(display_mem_addr_q);
  endproperty
  a_modify_read: assert property (p_modify_read) else $error("modify read moved addr");
  property p_immediate;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_ce && wr_raster |=> raster_area_control_q == $past(i_pwdata[7:0]);
  endproperty
  a_immediate: assert property (p_immediate) else $error("write not applied");
endmodule
`default_nettype wire

// ===== tb/osd_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module osd_cpu_model
  import osd_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_pready,
  input wire logic [31:0] i_prdata,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata
);
  logic hung = 1'b0;
  initial
  begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0000_0000;
  end
  // One register per transfer, so a byte never straddles two ports.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    begin
      n = 0;
      @(posedge i_ref_clk);
      o_psel <= 1'b1;
      o_pwrite <= wr;
      o_paddr <= a;
      o_pwdata <= d;
      @(posedge i_ref_clk);
      o_penable <= 1'b1;
      do
      begin
        @(posedge i_ref_clk);
        n++;
      end
      while (i_pready !== 1'b1 && n < 50);
      rd = i_prdata;
      err = i_pslverr;
      hung = hung | (n >= 50);
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      // Idle gap so the port sees spaced accesses, as a slow core would.
      repeat (2) @(posedge i_ref_clk);
    end
  endtask
  // Top address bit first, then the low byte, always both.
  task automatic set_addr(input logic [8:0] a);
    logic [31:0] rd;
    logic err;
    begin
      xfer(1'b1, OFS_ADDR_HIGH, {31'h0, a[8]}, rd, err);
      xfer(1'b1, OFS_ADDR_LOW, {24'h00_0000, a[7:0]}, rd, err);
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/osd_screen_planes_bench.sv
`timescale 1ns/1ps
`default_nettype none
module osd_screen_planes_bench;
  import osd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hd = 1'b0;
  logic vd_n = 1'b1;
  logic ce = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, blank, bsel, irq, irq_q, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  color_type color;
  int n_fail = 0;
  int samples_checked = 0;
  int irq_seen = 0;
  int irq_long = 0;
  osd_screen_planes #(.ADDR_W(9)) u_osd_screen_planes (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_ce(ce), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_horizontal_timing_pulse(hd), .i_vertical_timing_pulse_n(vd_n),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .o_osd_color(color),
    .o_osd_blank(blank), .o_blank_output_select(bsel), .o_irq(irq));
  osd_cpu_model u_osd_cpu_model (.i_ref_clk(clk), .i_pready(pready), .i_prdata(prdata),
    .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
    .o_paddr(paddr), .o_pwdata(pwdata));
  initial
  begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    irq_q <= irq;
    if (irq === 1'b1)
      irq_seen++;
    if (irq === 1'b1 && irq_q === 1'b1)
      irq_long++;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    u_osd_cpu_model.xfer(w, a, d, rd, er);
    if (u_osd_cpu_model.hung)
    begin
      n_fail++;
      results();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xf(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xf(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic pulse(input int h, input int n);
    repeat (n)
    begin
      if (h != 0) hd <= 1'b1; else vd_n <= 1'b0;
      repeat (6) @(posedge clk);
      if (h != 0) hd <= 1'b0; else vd_n <= 1'b1;
      repeat (6) @(posedge clk);
    end
  endtask
  task automatic t_reset_values();
    chk({28'h0, color}, 32'h0);
    rd_chk(OFS_WINDOW_TOP, {23'h0, RST_WINDOW_TOP});
    rd_chk(OFS_WINDOW_BOTTOM, {23'h0, RST_WINDOW_BOTTOM});
    rd_chk(OFS_ROW_HEIGHT, {24'h0, RST_ROW_HEIGHT});
    wr(OFS_LINE_COUNTER, 32'h5);
    rd_chk(OFS_LINE_COUNTER, 32'h0);
    rd_chk(8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask
  task automatic t_raster();
    wr(OFS_PIN_OUTPUT_SELECT, 32'h4);
    chk({31'h0, bsel}, 32'h1);
    for (int c = 0; c < 16; c++)
    begin
      wr(OFS_RASTER_AREA_CONTROL, 32'h40 | c);
      chk({27'h0, blank, color}, 32'h10 | c);
    end
    wr(OFS_RASTER_AREA_CONTROL, 32'h0);
    chk({31'h0, blank}, 32'h0);
  endtask
  task automatic t_planes();
    wr(OFS_PLANE1_RECT, 32'hFF00_FF00);
    wr(OFS_PLANE2_RECT, 32'hFF00_FF00);
    wr(OFS_AREA_PLANE_COLORS, 32'hA3);
    wr(OFS_RASTER_AREA_CONTROL, 32'h75);
    hd <= 1'b1;
    repeat (8) @(posedge clk);
    chk({28'h0, color}, 32'h3);
    wr(OFS_RASTER_AREA_CONTROL, 32'h65);
    chk({28'h0, color}, 32'hA);
    wr(OFS_RASTER_AREA_CONTROL, 32'h45);
    chk({28'h0, color}, 32'h5);
    hd <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic t_lines_irq();
    wr(OFS_ROW_HEIGHT, 32'h2);
    wr(OFS_OSD_INTERRUPT_CONTROL, 32'h2);
    pulse(0, 1);
    irq_seen = 0;
    pulse(1, 3);
    chk(irq_seen, 0);
    rd_chk(OFS_LINE_COUNTER, 32'h1);
    pulse(1, 1);
    chk(irq_seen, 1);
    rd_chk(OFS_LINE_COUNTER, 32'h2);
    wr(OFS_OSD_INTERRUPT_CONTROL, 32'h12);
    pulse(0, 1);
    chk(irq_seen, 2);
    rd_chk(OFS_LINE_COUNTER, 32'h0);
    wr(OFS_OSD_INTERRUPT_CONTROL, 32'h0);
    pulse(0, 1);
    pulse(1, 2);
    chk(irq_seen, 3);
    chk(irq_long, 0);
  endtask
  task automatic t_window();
    wr(OFS_RASTER_AREA_CONTROL, 32'h15);
    wr(OFS_OSD_MISC_CONTROL, 32'h1);
    // Limits move only while the field pulse is low, so no scan sees a half update.
    vd_n <= 1'b0;
    wr(OFS_WINDOW_BOTTOM, 32'h2);
    vd_n <= 1'b1;
    for (int s = 0; s < 3; s++)
    begin
      hd <= 1'b1;
      repeat (6) @(posedge clk);
      chk({27'h0, blank, color}, (s == 1) ? 32'h13 : 32'h0);
      hd <= 1'b0;
      repeat (6) @(posedge clk);
    end
    vd_n <= 1'b0;
    wr(OFS_WINDOW_BOTTOM, 32'h1FE);
    vd_n <= 1'b1;
    hd <= 1'b1;
    repeat (6) @(posedge clk);
    wr(OFS_OSD_MISC_CONTROL, 32'h0);
    chk({27'h0, blank, color}, 32'h13);
    rd_chk(OFS_WINDOW_BOTTOM, 32'h1FE);
    hd <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic t_ce();
    // A low enable must freeze the pulse synchronisers too, or edges would leak through.
    ce <= 1'b0;
    pulse(1, 2);
    ce <= 1'b1;
    rd_chk(OFS_LINE_COUNTER, 32'h0);
    pulse(1, 1);
    rd_chk(OFS_LINE_COUNTER, 32'h1);
    rd_chk(OFS_LINE_COUNTER, 32'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk({27'h0, blank, color}, 32'h0);
    rd_chk(OFS_LINE_COUNTER, 32'h0);
    rd_chk(OFS_RASTER_AREA_CONTROL, 32'h0);
  endtask
  task automatic t_memory();
    // No character rows are shown in this bench, so every location is free to write.
    u_osd_cpu_model.set_addr(9'h1FF);
    wr(OFS_CODE_HIGH, 32'h1);
    wr(OFS_CODE_LOW, 32'h23);
    rd_chk(OFS_ADDR_HIGH, 32'h0);
    wr(OFS_ATTRIBUTE, 32'h55);
    rd_chk(OFS_ADDR_LOW, 32'h1);
    u_osd_cpu_model.set_addr(9'h1FF);
    rd_chk(OFS_CODE_HIGH, 32'h1);
    rd_chk(OFS_CODE_LOW, 32'h23);
    rd_chk(OFS_ATTRIBUTE, 32'h55);
    wr(OFS_OSD_MISC_CONTROL, 32'h2);
    u_osd_cpu_model.set_addr(9'h005);
    wr(OFS_ATTRIBUTE, 32'h2A);
    rd_chk(OFS_ADDR_LOW, 32'h5);
    wr(OFS_CODE_HIGH, 32'h0);
    wr(OFS_CODE_LOW, 32'h77);
    rd_chk(OFS_ADDR_LOW, 32'h6);
    u_osd_cpu_model.set_addr(9'h005);
    rd_chk(OFS_ATTRIBUTE, 32'h2A);
    rd_chk(OFS_CODE_LOW, 32'h77);
    rd_chk(OFS_ADDR_LOW, 32'h6);
    wr(OFS_OSD_MISC_CONTROL, 32'h8);
    u_osd_cpu_model.set_addr(9'h005);
    rd_chk(OFS_CODE_LOW, 32'h77);
    rd_chk(OFS_ADDR_LOW, 32'h5);
    wr(OFS_ATTRIBUTE, 32'h11);
    rd_chk(OFS_ADDR_LOW, 32'h6);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_raster();
    t_planes();
    t_lines_irq();
    t_window();
    t_ce();
    t_memory();
    results();
  end
endmodule
`default_nettype wire
